// ---- rtl/fabric_gate_cfg.svh ----
// constants for the fabric configuration request gate
`ifndef FABRIC_GATE_CFG_SVH
`define FABRIC_GATE_CFG_SVH
`define REQ_KIND_W 2
`define KIND_CFG_RD 2'h0
`define KIND_CFG_WR 2'h1
`define KIND_MEM 2'h2
`define KIND_IO 2'h3
`define STAT_W 3
`define STAT_OK 3'h0
`define STAT_UR 3'h1
`define STAT_CRS 3'h2
`define TAG_W 8
`endif

// ---- rtl/fabric_gate_pkg.sv ----
// types for the fabric configuration request gate
`include "fabric_gate_cfg.svh"
package fabric_gate_pkg;
	typedef struct packed
	{
		logic [`REQ_KIND_W-1:0] kind;
		logic [`TAG_W-1:0]      tag;
	} req_t;

	typedef struct packed
	{
		logic [`STAT_W-1:0] status;
		logic [`TAG_W-1:0]  tag;
	} cpl_t;

	typedef enum logic [2:0]
	{
		ST_RESET,
		ST_PERIPH_LOAD,
		ST_LINK_UP,
		ST_FABRIC_LOAD,
		ST_READY
	} phase_t;
endpackage

// ---- rtl/pcie_fabric_config_gate.sv ----
// request gate and load sequencing of the endpoint during fabric configuration
//
// Overview of operation
// - fabric not ready: config reads and writes get retry-status completions
// - fabric not ready: memory and I/O requests get unsupported request completions
// - after own settings load, endpoint starts link training without waiting for fabric
// - periphery image always finishes loading before fabric configuration begins
// - endpoint set for config over link runs as endpoint only, never root
// - fabric image update over the link needs no host reboot or chip reinit
// - only the designated hard block reaches the config controller
// - periphery_done permits link training; fabric_config_done marks fabric configured
`timescale 1ns/1ns
`include "fabric_gate_cfg.svh"
module pcie_fabric_config_gate
(
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   periph_load_ok,
	input  wire logic                   fabric_load_ok,
	input  wire logic                   fabric_update_start,
	input  wire logic                   designated_block,
	input  wire logic                   root_role_req,
	input  wire logic                   config_over_link,
	input  wire logic                   req_valid,
	input  wire fabric_gate_pkg::req_t  req,
	output logic                        periphery_done,
	output logic                        fabric_config_done,
	output logic                        link_train_en,
	output logic                        fabric_load_en,
	output logic                        endpoint_role,
	output logic                        cpl_valid,
	output fabric_gate_pkg::cpl_t       cpl,
	output logic                        fwd_valid,
	output fabric_gate_pkg::req_t       fwd_req
);
	// pins from the configuration side are asynchronous
	logic [1:0]               periph_sync;
	logic [1:0]               fabric_sync;
	logic [1:0]               update_sync;
	logic                     update_seen;
	fabric_gate_pkg::phase_t  phase;
	fabric_gate_pkg::phase_t  next_phase;
	logic                     fabric_ready;

	// two-flop synchroniser for the periphery done level
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			periph_sync <= 2'h0;
		else
			periph_sync <= {periph_sync[0], periph_load_ok};
	end

	// two-flop synchroniser for the fabric done level
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fabric_sync <= 2'h0;
		else
			fabric_sync <= {fabric_sync[0], fabric_load_ok};
	end

	// two-flop synchroniser for the update request
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			update_sync <= 2'h0;
		else
			update_sync <= {update_sync[0], fabric_update_start};
	end

	wire periph_ok    = periph_sync[1];
	wire fabric_ok    = fabric_sync[1];
	wire update_rise  = update_sync[1] & ~update_seen;
	wire link_cfg_capable = config_over_link & designated_block;
	wire update_go        = update_rise & link_cfg_capable
		& (phase == fabric_gate_pkg::ST_READY);

	always_comb
	begin
		next_phase = phase;
		unique case (phase)
			fabric_gate_pkg::ST_RESET:
				next_phase = fabric_gate_pkg::ST_PERIPH_LOAD;
			fabric_gate_pkg::ST_PERIPH_LOAD:
				if (periph_ok)
					next_phase = fabric_gate_pkg::ST_LINK_UP;
			fabric_gate_pkg::ST_LINK_UP:
				if (link_cfg_capable)
					next_phase = fabric_gate_pkg::ST_FABRIC_LOAD;
				else if (fabric_ok)
					next_phase = fabric_gate_pkg::ST_READY;
			fabric_gate_pkg::ST_FABRIC_LOAD:
				if (fabric_ok)
					next_phase = fabric_gate_pkg::ST_READY;
			fabric_gate_pkg::ST_READY:
				if (update_go)
					next_phase = fabric_gate_pkg::ST_FABRIC_LOAD;
		endcase
	end

	// the fabric done level must drop during an update before it is trusted again
	logic fabric_ok_armed;

	wire next_update_seen = update_sync[1];
	wire next_armed       = update_go ? 1'b0 : (fabric_ok_armed | ~fabric_ok);
	wire hold_phase       = (phase == fabric_gate_pkg::ST_FABRIC_LOAD) & ~fabric_ok_armed;

	// previous update level for edge detection
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			update_seen <= 1'b0;
		else
			update_seen <= next_update_seen;
	end

	// stale done guard, cleared by an update
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			fabric_ok_armed <= 1'b0;
		else
			fabric_ok_armed <= next_armed;
	end

	// load sequence, held while the done level is stale
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			phase <= fabric_gate_pkg::ST_RESET;
		else if (!hold_phase)
			phase <= next_phase;
	end

	assign fabric_ready = (phase == fabric_gate_pkg::ST_READY);

	// request decoding
	wire is_cfg_rd = (req.kind == `KIND_CFG_RD);
	wire is_cfg_wr = (req.kind == `KIND_CFG_WR);
	wire is_cfg    = is_cfg_rd | is_cfg_wr;
	wire gate_on   = req_valid & ~fabric_ready;
	wire pass_on   = req_valid & fabric_ready;
	wire [`STAT_W-1:0] gate_stat = is_cfg ? `STAT_CRS : `STAT_UR;

	// phase decoding for the status outputs
	wire past_periph      = (phase != fabric_gate_pkg::ST_RESET)
		&& (phase != fabric_gate_pkg::ST_PERIPH_LOAD);
	wire next_periph_done = past_periph;
	wire next_train_en    = past_periph;
	wire next_cfg_done    = fabric_ready;
	wire next_load_en     = (phase == fabric_gate_pkg::ST_FABRIC_LOAD);
	// a link-configured block never takes the root role
	wire next_endpoint    = config_over_link | ~root_role_req;

	// periphery and training status
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			periphery_done <= 1'b0;
			link_train_en  <= 1'b0;
		end
		else
		begin
			periphery_done <= next_periph_done;
			link_train_en  <= next_train_en;
		end
	end

	// fabric status
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fabric_config_done <= 1'b0;
			fabric_load_en     <= 1'b0;
		end
		else
		begin
			fabric_config_done <= next_cfg_done;
			fabric_load_en     <= next_load_en;
		end
	end

	// role strap
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			endpoint_role <= 1'b1;
		else
			endpoint_role <= next_endpoint;
	end

	// gated completions while the fabric is not ready
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cpl_valid <= 1'b0;
			cpl       <= '0;
		end
		else
		begin
			cpl_valid  <= gate_on;
			cpl.status <= gate_stat;
			cpl.tag    <= req.tag;
		end
	end

	// forwarding once the fabric is ready
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fwd_valid <= 1'b0;
			fwd_req   <= '0;
		end
		else
		begin
			fwd_valid <= pass_on;
			fwd_req   <= req;
		end
	end
endmodule // pcie_fabric_config_gate

// ---- verif/gate_props_properties.sv ----
// assertions on the request gate ports
`timescale 1ns/1ns
module gate_props
(
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  req_valid,
	input wire logic                  cpl_valid,
	input wire logic                  fwd_valid,
	input wire logic                  periphery_done,
	input wire logic                  link_train_en,
	input wire logic                  fabric_config_done,
	input wire logic                  fabric_load_en,
	input wire logic                  endpoint_role,
	input wire logic                  config_over_link,
	input wire fabric_gate_pkg::req_t req,
	input wire fabric_gate_pkg::req_t fwd_req,
	input wire fabric_gate_pkg::cpl_t cpl
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_crs;
		req_valid&&!periphery_done&&!req.kind[1]|=>cpl_valid&&cpl.status==3'h2;
	endproperty
	a_crs: assert property(p_crs) else $error("no retry");
	property p_ur;
		req_valid&&!periphery_done&&req.kind[1]|=>cpl_valid&&cpl.status==3'h1;
	endproperty
	a_ur: assert property(p_ur) else $error("no unsupported");
	property p_tag;
		cpl_valid|->$past(req_valid)&&cpl.tag==$past(req.tag);
	endproperty
	a_tag: assert property(p_tag) else $error("bad tag");
	property p_fwd;
		req_valid&&fabric_config_done##1 fabric_config_done|->fwd_valid&&fwd_req==$past(req);
	endproperty
	a_fwd: assert property(p_fwd) else $error("not forwarded");
	property p_lt;
		periphery_done==link_train_en;
	endproperty
	a_lt: assert property(p_lt) else $error("training");
	property p_ld;
		fabric_load_en|->periphery_done&&config_over_link;
	endproperty
	a_ld: assert property(p_ld) else $error("early load");
	property p_fd;
		fabric_config_done|->periphery_done&&!fabric_load_en;
	endproperty
	a_fd: assert property(p_fd) else $error("done order");
	property p_ep;
		config_over_link&&$past(config_over_link)|->endpoint_role;
	endproperty
	a_ep: assert property(p_ep) else $error("role");
	c_crs: cover property(cpl_valid&&cpl.status==3'h2);
	c_fwd: cover property(fwd_valid);
	c_upd: cover property($fell(fabric_config_done));
endmodule // gate_props
bind pcie_fabric_config_gate gate_props u_props(.*);

// ---- verif/host_model.sv ----
// host side issuing requests to the endpoint
`timescale 1ns/1ns
module host_model
(
	input  wire logic             go,
	input  wire logic [9:0]       r,
	output logic                  req_valid,
	output fabric_gate_pkg::req_t req
);
	assign req_valid = go; // valid follows go; gated requests are not issued again
	assign req = r;
endmodule // host_model

// ---- verif/tb_pcie_fabric_config_gate.sv ----
// self-checking bench for the request gate
`timescale 1ns/1ns
module tb_pcie_fabric_config_gate;
	logic clk=0,rst_b=0,periph_load_ok=0,fabric_load_ok=0,fabric_update_start=0,go=0,g=1;
	logic designated_block=1,root_role_req=1,config_over_link=1,req_valid,periphery_done;
	logic fabric_config_done,link_train_en,fabric_load_en,endpoint_role,cpl_valid,fwd_valid;
	logic [10:0] cpl,q[$];
	logic [9:0] r=0,req,fwd_req;
	logic [31:0] s=32'h7643;
	int num_errors=0,checks_done=0,i;
	wire logic [2:0] st={fabric_config_done,fabric_load_en,periphery_done};
	always #25 clk=~clk;
	host_model hm(.go,.r,.req_valid,.req);
	pcie_fabric_config_gate uut(.*);
	task chk(input string n,input logic [10:0] e,v);
		checks_done++;
		if(v!==e)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h",n,e,v);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d",checks_done,num_errors);
		if(num_errors==0&&checks_done>0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t=v^(v<<13);
		t=t^(t>>17);
		xs=t^(t<<5);
	endfunction
	task snd(input logic [1:0] k);
		s=xs(s);
		r={k,s[7:0]};
		go=1;
		q.push_back({g?{1'b0,!k[1],k[1]}:3'h7,s[7:0]});
		#50;
	endtask
	task wt(input int b,input logic v);
		for(i=0;i<60&&st[b]!==v;i++)
			#50;
		chk("state",v,st[b]);
		if(i==60)
			tally_and_finish;
	endtask
	always @(negedge clk)
		if(cpl_valid|fwd_valid)
			chk("answer",q.size()?q.pop_front():11'h7ff,fwd_valid?{3'h7,fwd_req[7:0]}:cpl);
	initial
	begin
		#176 rst_b=1;
		for(i=0;i<4;i++)
			snd(i[1:0]);
		go=0;
		periph_load_ok=1;
		wt(0,1);
		chk("link",1,link_train_en);
		chk("role",1,endpoint_role);
		wt(1,1);
		snd(2'h0);
		snd(2'h3);
		go=0;
		fabric_load_ok=1;
		wt(2,1);
		g=0;
		repeat(3) snd(s[1:0]);
		go=0;
		fabric_update_start=1;
		fabric_load_ok=0;
		wt(2,0);
		g=1;
		snd(2'h1);
		go=0;
		fabric_load_ok=1;
		wt(2,1);
		g=0;
		snd(2'h2);
		go=0;
		#200;
		chk("left",0,q.size());
		tally_and_finish;
	end
endmodule // tb_pcie_fabric_config_gate
